// ### tb.sv
// Self-checking testbench of the 8-bit timer/counter unit.
`timescale 1ns/1ns
module tb;
    import timer_pkg::*;

    logic clk;
    logic srst;
    logic pwr_off;
    logic async_sel;
    logic [2:0] cs;
    logic [2:0] mode;
    logic osc_in;
    logic osc_out;
    cpu_write_s cw;
    logic [2:0] fclr;
    logic [2:0] mask;
    logic [7:0] cnt;
    logic [7:0] cmpa;
    logic [7:0] cmpb;
    logic [2:0] flags;
    logic [2:0] irq;
    logic [2:0] busy;
    logic top_ind;
    logic max_ind;
    logic bottom_ind;
    logic out_a;
    logic out_b;
    int n_mismatch = 0;
    int total_checks = 0;

    timer_unit dut (.clk(clk), .srst(srst), .timer_power_off_bit(pwr_off),
        .async_clock_select(async_sel), .clock_select_field(cs),
        .wave_mode_field(mode), .osc_pin_one(osc_in), .osc_pin_two(osc_out),
        .cpu_write(cw), .flag_clear(fclr), .timer_mask_reg(mask),
        .counter_value(cnt), .compare_a_value(cmpa), .compare_b_value(cmpb),
        .timer_flag_reg(flags), .irq_req(irq), .async_status_reg(busy),
        .top_ind(top_ind), .max_ind(max_ind), .bottom_ind(bottom_ind),
        .compare_out_a(out_a), .compare_out_b(out_b));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk3(input logic [2:0] got, input logic [2:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk3

    task automatic chk1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk1

    // Selector: 0 counter, 1 compare A, 2 compare B; one-cycle pulse.
    task automatic wr(input int sel, input logic [7:0] d);
        @(negedge clk);
        cw.cnt_we = (sel == 0);
        cw.cmpa_we = (sel == 1);
        cw.cmpb_we = (sel == 2);
        cw.data = d;
        @(negedge clk);
        cw = '0;
    endtask : wr

    // Exactly n synchronous ticks at divide-by-one (none while powered off), then stopped again.
    task automatic run(input int n);
        @(negedge clk);
        cs = CS_DIV1;
        repeat (n) @(negedge clk);
        cs = CS_STOP;
    endtask : run

    task automatic clr(input logic [2:0] b);
        @(negedge clk);
        fclr = b;
        @(negedge clk);
        fclr = 3'h0;
    endtask : clr

    initial begin
        #200000;
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        int i;
        srst = 1'b1;
        pwr_off = 1'b0;
        async_sel = 1'b0;
        cs = CS_STOP;
        mode = WM_NORMAL;
        osc_in = 1'b0;
        cw = '0;
        fclr = 3'h0;
        mask = 3'h0;
        repeat (20) @(negedge clk);
        srst = 1'b0;
        chk8(cnt, 8'h00);
        chk1(bottom_ind, 1'b1);
        chk3(flags, 3'h0);
        wr(1, 8'h30);
        wr(2, 8'h31);
        chk8(cmpa, 8'h30);
        chk8(cmpb, 8'h31);
        wr(0, 8'h2E);
        repeat (5) @(negedge clk);
        chk8(cnt, 8'h2E);
        run(2);
        chk8(cnt, 8'h30);
        chk3(flags, 3'h0);
        run(1);
        chk3(flags, 3'h2);
        chk1(out_a, 1'b1);
        run(1);
        chk3(flags, 3'h6);
        chk1(out_b, 1'b1);
        mask = 3'h4;
        #1;
        chk3(irq, 3'h4);
        mask = 3'h3;
        #1;
        chk3(irq, 3'h2);
        clr(3'h7);
        chk3(flags, 3'h0);
        // A counter write equal to compare A must not raise its flag.
        wr(0, 8'h30);
        run(1);
        chk8(cnt, 8'h31);
        chk3(flags, 3'h0);
        run(1);
        chk3(flags, 3'h4);
        chk1(out_b, 1'b0);
        clr(3'h7);
        wr(0, 8'hFE);
        chk1(max_ind, 1'b0);
        run(1);
        chk8(cnt, 8'hFF);
        chk1(max_ind, 1'b1);
        chk1(top_ind, 1'b1);
        run(1);
        chk8(cnt, 8'h00);
        chk3(flags, 3'h1);
        chk1(bottom_ind, 1'b1);
        chk3(irq, 3'h1);
        @(negedge clk);
        cs = CS_DIV1;
        cw.cnt_we = 1'b1;
        cw.data = 8'h55;
        @(negedge clk);
        cs = CS_STOP;
        cw = '0;
        chk8(cnt, 8'h55);
        pwr_off = 1'b1;
        run(3);
        chk8(cnt, 8'h55);
        pwr_off = 1'b0;
        clr(3'h7);
        mode = WM_CTC;
        wr(1, 8'h05);
        wr(0, 8'h03);
        run(2);
        chk8(cnt, 8'h05);
        chk1(top_ind, 1'b1);
        chk1(max_ind, 1'b0);
        run(1);
        chk8(cnt, 8'h00);
        chk3(flags, 3'h2);
        chk1(out_a, 1'b0);
        mode = WM_PHASE_MAX;
        wr(0, 8'hFE);
        run(2);
        chk8(cnt, 8'hFE);
        mode = WM_NORMAL;
        wr(0, 8'h10);
        @(negedge clk);
        cs = CS_DIV8;
        repeat (16) @(negedge clk);
        cs = CS_STOP;
        // Sixteen base ticks at divide-by-eight give two ticks, any phase.
        chk8(cnt, 8'h12);
        @(negedge clk);
        // Oscillator selected but still: no tick may come from clk.
        mode = WM_NORMAL;
        async_sel = 1'b1;
        cs = CS_DIV1;
        repeat (10) @(negedge clk);
        chk8(cnt, 8'h12);
        wr(0, 8'h40);
        chk1(busy[BUSY_CNT], 1'b1);
        chk8(cnt, 8'h12);
        i = 0;
        while (busy[BUSY_CNT] !== 1'b0 && i < 20) begin
            osc_in = 1'b1;
            @(negedge clk);
            osc_in = 1'b0;
            @(negedge clk);
            i++;
        end
        chk1(busy[BUSY_CNT], 1'b0);
        chk8(cnt, 8'h40);
        osc_in = 1'b1;
        @(negedge clk);
        chk1(osc_out, 1'b0);
        osc_in = 1'b0;
        @(negedge clk);
        chk1(osc_out, 1'b1);
        tally_and_finish();
    end
endmodule : tb

// ### timer_pkg.sv
// Shared constants, modes and carrier types of the 8-bit timer/counter.
package timer_pkg;

    localparam logic [7:0] BOTTOM_VAL = 8'h00;
    localparam logic [7:0] MAX_VAL = 8'hFF;
    localparam logic [7:0] COUNT_STEP = 8'h01;
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [9:0] PRESCALE_STEP = 10'h001;

    // Bit positions inside the flag, mask and busy vectors.
    localparam int FLAG_OVF = 0;
    localparam int FLAG_CMPA = 1;
    localparam int FLAG_CMPB = 2;
    localparam int BUSY_CNT = 0;
    localparam int BUSY_CMPA = 1;
    localparam int BUSY_CMPB = 2;

    typedef enum logic [2:0] {
        WM_NORMAL = 3'b000,
        WM_PHASE_MAX = 3'b001,
        WM_CTC = 3'b010,
        WM_FAST_MAX = 3'b011,
        WM_RESERVED_4 = 3'b100,
        WM_PHASE_CMPA = 3'b101,
        WM_RESERVED_6 = 3'b110,
        WM_FAST_CMPA = 3'b111
    } wave_mode_e;

    typedef struct packed {
        logic cnt_we;
        logic cmpa_we;
        logic cmpb_we;
        logic [7:0] data;
    } cpu_write_s;

    typedef struct packed {
        logic [7:0] counter;
        logic [7:0] cmpa;
        logic [7:0] cmpb;
        logic [2:0] flags;
        logic down;
        logic [9:0] prescaler;
        logic osc_prev;
        logic block;
        logic [7:0] pend_cnt;
        logic [7:0] pend_a;
        logic [7:0] pend_b;
        logic [2:0] busy;
        logic out_a;
        logic out_b;
        logic osc_drive;
    } timer_state_s;

    localparam timer_state_s STATE_RESET = '0;

endpackage : timer_pkg

// ### timer_unit.sv
// Timer/counter core: tick selection, counter, compare, flags, waveform.
`timescale 1ns/1ns
module timer_unit
    import timer_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic timer_power_off_bit,
    input wire logic async_clock_select,
    input wire logic [2:0] clock_select_field,
    input wire logic [2:0] wave_mode_field,
    input wire logic osc_pin_one,
    output logic osc_pin_two,
    input wire cpu_write_s cpu_write,
    input wire logic [2:0] flag_clear,
    input wire logic [2:0] timer_mask_reg,
    output logic [7:0] counter_value,
    output logic [7:0] compare_a_value,
    output logic [7:0] compare_b_value,
    output logic [2:0] timer_flag_reg,
    output logic [2:0] irq_req,
    output logic [2:0] async_status_reg,
    output logic top_ind,
    output logic max_ind,
    output logic bottom_ind,
    output logic compare_out_a,
    output logic compare_out_b
);

    timer_state_s st;
    timer_state_s next_st;
    wave_mode_e mode;
    logic running;
    logic direct;
    logic base_tick;
    logic tick;
    logic apply_cnt;
    logic apply_a;
    logic apply_b;
    logic [7:0] cnt_val;
    logic [7:0] top_value;
    logic match_a;
    logic match_b;
    logic cnt_clear;
    logic cnt_count;
    logic cnt_down;
    logic ovf_set;
    logic pwm_fast;
    logic pwm_phase;

    // Tick of the selected division: the prescaler low bits all ones.
    function automatic logic prescale_hit(input logic [2:0] sel,
                                          input logic [9:0] pre);
        logic hit;
        hit = 1'b0;
        case (sel)
            CS_DIV1: hit = 1'b1;
            CS_DIV8: hit = &pre[2:0];
            CS_DIV64: hit = &pre[5:0];
            CS_DIV256: hit = &pre[7:0];
            default: hit = &pre;
        endcase
        return hit;
    endfunction : prescale_hit

    // The oscillator pin is sampled; its rising edge is one base tick.
    function automatic logic rose(input logic now, input logic prev);
        return now & ~prev;
    endfunction : rose

    always_comb begin
        next_st = st;
        mode = wave_mode_e'(wave_mode_field);
        running = !timer_power_off_bit
                  && clock_select_field != CS_STOP;
        // A 32 kHz crystal drives the pin; the core clock oversamples it.
        base_tick = running
                    && (async_clock_select
                        ? rose(osc_pin_one, st.osc_prev)
                        : 1'b1);
        tick = base_tick
               && prescale_hit(clock_select_field, st.prescaler);
        next_st.osc_prev = osc_pin_one;
        next_st.osc_drive = ~osc_pin_one;
        if (base_tick) begin
            next_st.prescaler = st.prescaler + PRESCALE_STEP;
        end
        // With the oscillator running, writes wait in staging registers
        // and land whole on a tick, so the tick never sees half a value.
        direct = !(async_clock_select && running);
        apply_cnt = direct ? cpu_write.cnt_we
                           : (tick && st.busy[BUSY_CNT]);
        apply_a = direct ? cpu_write.cmpa_we
                         : (tick && st.busy[BUSY_CMPA]);
        apply_b = direct ? cpu_write.cmpb_we
                         : (tick && st.busy[BUSY_CMPB]);
        cnt_val = direct ? cpu_write.data : st.pend_cnt;
        if (tick) begin
            next_st.busy = 3'h0;
        end
        if (!direct) begin
            if (cpu_write.cnt_we) begin
                next_st.pend_cnt = cpu_write.data;
                next_st.busy[BUSY_CNT] = 1'b1;
            end
            if (cpu_write.cmpa_we) begin
                next_st.pend_a = cpu_write.data;
                next_st.busy[BUSY_CMPA] = 1'b1;
            end
            if (cpu_write.cmpb_we) begin
                next_st.pend_b = cpu_write.data;
                next_st.busy[BUSY_CMPB] = 1'b1;
            end
        end
        if (apply_a) begin
            next_st.cmpa = direct ? cpu_write.data : st.pend_a;
        end
        if (apply_b) begin
            next_st.cmpb = direct ? cpu_write.data : st.pend_b;
        end

        pwm_fast = mode == WM_FAST_MAX || mode == WM_FAST_CMPA;
        pwm_phase = mode == WM_PHASE_MAX || mode == WM_PHASE_CMPA;
        // Compare A sets the top in CTC and both compare-A PWM modes.
        top_value = (mode == WM_CTC || mode == WM_PHASE_CMPA
                     || mode == WM_FAST_CMPA)
                    ? st.cmpa : MAX_VAL;

        // Equality is held in the counter and acted on at the next tick.
        match_a = tick && !st.block && st.counter == st.cmpa;
        match_b = tick && !st.block && st.counter == st.cmpb;

        cnt_count = tick;
        cnt_down = st.down;
        cnt_clear = 1'b0;
        ovf_set = 1'b0;
        case (mode)
            WM_CTC: begin
                // A counter write blocks this match, and so the clear too.
                cnt_clear = tick && !st.block
                            && st.counter == st.cmpa;
                ovf_set = tick && st.counter == MAX_VAL;
            end
            WM_FAST_MAX, WM_FAST_CMPA: begin
                cnt_clear = tick && st.counter == top_value;
                ovf_set = cnt_clear;
            end
            WM_PHASE_MAX, WM_PHASE_CMPA: begin
                if (!st.down && st.counter == top_value) begin
                    cnt_down = 1'b1;
                end else if (st.down && st.counter == BOTTOM_VAL) begin
                    cnt_down = 1'b0;
                end
                ovf_set = tick && cnt_down
                          && st.counter == COUNT_STEP;
            end
            default: begin
                cnt_down = 1'b0;
                ovf_set = tick && st.counter == MAX_VAL;
            end
        endcase
        if (tick) begin
            next_st.down = cnt_down;
        end
        if (cnt_clear) begin
            next_st.counter = BOTTOM_VAL;
        end else if (cnt_count) begin
            next_st.counter = cnt_down ? st.counter - COUNT_STEP
                                       : st.counter + COUNT_STEP;
        end
        if (apply_cnt) begin
            next_st.counter = cnt_val;
        end

        // The block covers exactly one tick after the write lands.
        if (tick) begin
            next_st.block = 1'b0;
        end
        if (apply_cnt) begin
            next_st.block = 1'b1;
        end

        // Hardware set wins over a clear in the same cycle.
        next_st.flags = st.flags & ~flag_clear;
        next_st.flags[FLAG_OVF] = next_st.flags[FLAG_OVF] | ovf_set;
        next_st.flags[FLAG_CMPA] = next_st.flags[FLAG_CMPA]
                                   | match_a;
        next_st.flags[FLAG_CMPB] = next_st.flags[FLAG_CMPB]
                                   | match_b;

        // Non-PWM modes toggle; fast PWM sets at bottom, clears on match;
        // phase correct clears on match upward and sets downward.
        if (pwm_fast) begin
            if (match_a) begin
                next_st.out_a = 1'b0;
            end else if (ovf_set) begin
                next_st.out_a = 1'b1;
            end
            if (match_b) begin
                next_st.out_b = 1'b0;
            end else if (ovf_set) begin
                next_st.out_b = 1'b1;
            end
        end else if (pwm_phase) begin
            if (match_a) begin
                next_st.out_a = cnt_down;
            end
            if (match_b) begin
                next_st.out_b = cnt_down;
            end
        end else begin
            if (match_a) begin
                next_st.out_a = ~st.out_a;
            end
            if (match_b) begin
                next_st.out_b = ~st.out_b;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st <= STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign counter_value = st.counter;
    assign compare_a_value = st.cmpa;
    assign compare_b_value = st.cmpb;
    assign timer_flag_reg = st.flags;
    assign irq_req = st.flags & timer_mask_reg;
    assign async_status_reg = st.busy;
    assign top_ind = st.counter == top_value;
    assign max_ind = st.counter == MAX_VAL;
    assign bottom_ind = st.counter == BOTTOM_VAL;
    assign compare_out_a = st.out_a;
    assign compare_out_b = st.out_b;
    assign osc_pin_two = st.osc_drive;

    sequence stop_idle;
        clock_select_field == CS_STOP && !cpu_write.cnt_we;
    endsequence

    sequence normal_top_tick;
        mode == WM_NORMAL && tick && st.counter == MAX_VAL && !apply_cnt;
    endsequence

    sequence staged_landing;
        !direct && tick && st.busy[BUSY_CNT] && !cpu_write.cnt_we;
    endsequence

    sequence phase_top_tick;
        pwm_phase && tick && !st.down && st.counter == top_value
        && !apply_cnt;
    endsequence

    stop_holds_a:
        assert property (@(posedge clk) disable iff (srst)
        stop_idle |=> $stable(counter_value))
        else $error("counter moved while stopped");

    power_hold_a:
        assert property (@(posedge clk) disable iff (srst)
        timer_power_off_bit && !cpu_write.cnt_we
        |=> $stable(counter_value))
        else $error("counter moved while powered off");

    write_wins_a:
        assert property (@(posedge clk) disable iff (srst)
        direct && cpu_write.cnt_we |=> counter_value == $past(cpu_write.data))
        else $error("counter write lost");

    match_flag_a:
        assert property (@(posedge clk) disable iff (srst)
        tick && !st.block && st.counter == st.cmpa
        |=> timer_flag_reg[FLAG_CMPA])
        else $error("compare A flag not set");

    match_block_a:
        assert property (@(posedge clk) disable iff (srst)
        tick && st.block && !st.flags[FLAG_CMPB]
        |=> !timer_flag_reg[FLAG_CMPB])
        else $error("blocked match set flag");

    block_cmpa_a:
        assert property (@(posedge clk) disable iff (srst)
        tick && st.block && !st.flags[FLAG_CMPA]
        |=> !timer_flag_reg[FLAG_CMPA])
        else $error("blocked match set compare A flag");

    normal_wrap_a:
        assert property (@(posedge clk) disable iff (srst)
        normal_top_tick |=> bottom_ind && timer_flag_reg[FLAG_OVF])
        else $error("normal wrap wrong");

    ctc_clear_a:
        assert property (@(posedge clk) disable iff (srst)
        mode == WM_CTC && tick && st.counter == st.cmpa
        && !st.block && !apply_cnt
        |=> counter_value == BOTTOM_VAL)
        else $error("ctc did not clear");

    count_step_a:
        assert property (@(posedge clk) disable iff (srst)
        mode == WM_NORMAL && tick && !apply_cnt
        |=> counter_value == $past(st.counter) + COUNT_STEP)
        else $error("count step wrong");

    phase_turn_a:
        assert property (@(posedge clk) disable iff (srst)
        phase_top_tick |=> counter_value == $past(st.counter) - COUNT_STEP)
        else $error("phase mode did not turn down at top");

    irq_follow_a:
        assert property (@(posedge clk) disable iff (srst)
        $rose(timer_flag_reg[FLAG_OVF]) && timer_mask_reg[FLAG_OVF]
        |-> irq_req[FLAG_OVF] ##1 (irq_req[FLAG_OVF]
                                   || !timer_mask_reg[FLAG_OVF]
                                   || flag_clear[FLAG_OVF] == 1'b1
                                   || $past(flag_clear[FLAG_OVF])))
        else $error("masked request wrong");

    staged_write_a:
        assert property (@(posedge clk) disable iff (srst)
        staged_landing |=> counter_value == $past(st.pend_cnt)
                           && !async_status_reg[BUSY_CNT])
        else $error("staged write did not land");

    staged_cmpa_a:
        assert property (@(posedge clk) disable iff (srst)
        !direct && tick && st.busy[BUSY_CMPA] && !cpu_write.cmpa_we
        |=> compare_a_value == $past(st.pend_a))
        else $error("staged compare A lost");

endmodule : timer_unit
